// ===== rtl/cfm_regs.vh
// Register map and constants of the clock fail monitor
`ifndef CFM_REGS_VH
`define CFM_REGS_VH

// Register byte offsets
`define CFM_CTRL_OFS 8'h00
`define CFM_EVENT_CONTROL_OFS 8'h04
`define CFM_IRQ_MASK_OFS 8'h08
`define CFM_IRQ_FLAG_OFS 8'h0c
`define CFM_STATUS_OFS 8'h10

// Control register fields
`define CFM_CTRL_OSC_EN 0
`define CFM_CTRL_MON_EN 1
`define CFM_CTRL_RESTORE 2
`define CFM_CTRL_STARTUP_LSB 4
`define CFM_CTRL_STARTUP_MSB 7
`define CFM_CTRL_PRESC_LSB 8
`define CFM_CTRL_PRESC_MSB 9

// Event control field
`define CFM_EV_OUT_EN 0

// Interrupt flag and mask layout
`define CFM_IRQ_FAIL 0
`define CFM_IRQ_READY 1
`define CFM_IRQ_W 2

// Status fields
`define CFM_ST_FAIL 0
`define CFM_ST_SWITCHED 1
`define CFM_ST_READY 2
`define CFM_ST_ACTIVE 3

// Reset values
`define CFM_CTRL_RST 10'h000
`define CFM_CTRL_OSC_EN_RST 1'b0
`define CFM_CTRL_MON_EN_RST 1'b0
`define CFM_CTRL_STARTUP_RST 4'h0
`define CFM_CTRL_PRESC_RST 2'h0
`define CFM_EDGE_IDLE 1'b0
`define CFM_EVENT_CONTROL_RST 1'h0
`define CFM_IRQ_RST 2'h0

// Timing counts
`define CFM_WINDOW_TICKS 2'h3
`define CFM_STARTUP_W 16

`endif

// ===== rtl/cfm_clock_fail_monitor.v
// Clock fail monitor with safe clock substitution and APB registers
//
// Notes on behaviour
// - State and configuration are cleared only by power-on reset.
// - With the oscillator enable cleared, nothing is monitored and no failure shown.
// - Monitoring starts when software writes one to the monitor enable bit.
// - After oscillator start or restart, failures are ignored until start-up elapses.
// - Window of four safe clocks needs a rising and a falling edge.
// - A failure sets the clock fail status bit and the interrupt flag.
// - The interrupt request is raised only when its enable bit is set.
// - The failure event is issued only when its output enable is set.
// - Monitoring continues; the fail status follows present clock activity.
// - On failure the safe clock replaces the external clock downstream.
// - Safe clock is internal fast oscillator divided by a selectable prescaler.
// - The substitution sets the clock switched status bit.
// - Switching never disables the external oscillator; software does that.
// - Software may switch back to the external clock after recovery.
// - In sleep, monitoring halts unless a peripheral requests the oscillator.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "cfm_regs.vh"

module cfm_clock_fail_monitor (
  // Clock, power-on reset, clock enable
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Oscillator clocks, sampled in mclk
  input wire ext_osc_clk,
  input wire internal_fast_osc_clk,
  // Sleep control
  input wire sleep_mode,
  input wire ext_osc_request,
  // Oscillator control and clock outputs
  output reg ext_osc_enable,
  output reg safe_clk,
  output reg clk_out,
  output reg clk_select_safe,
  // Event and interrupt
  output reg fail_event,
  output wire irq
);

  // Software state
  reg osc_en_bit;
  reg fail_monitor_enable;
  reg [3:0] startup_sel;
  reg [1:0] presc_sel;
  reg fail_event_output_enable;
  reg [`CFM_IRQ_W-1:0] irq_mask;
  reg [`CFM_IRQ_W-1:0] irq_flag;

  // Monitor state
  reg clock_fail_flag;
  reg clock_switched_flag;
  reg osc_ready;
  wire ext_q;
  reg [7:0] presc_cnt;
  reg [1:0] win_cnt;
  reg rise_seen;
  reg fall_seen;
  reg [`CFM_STARTUP_W-1:0] startup_cnt;

  // Bus decode
  wire setup_ph;
  wire access_ph;
  wire wr_acc;
  wire rd_acc;
  wire hit_ctrl;
  wire hit_ev;
  wire hit_mask;
  wire hit_flag;
  wire hit_status;
  wire mapped;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready = access_ph;
  assign wr_acc = access_ph & pwrite & clk_en;
  assign rd_acc = access_ph & ~pwrite & clk_en;
  assign hit_ctrl = (paddr == `CFM_CTRL_OFS);
  assign hit_ev = (paddr == `CFM_EVENT_CONTROL_OFS);
  assign hit_mask = (paddr == `CFM_IRQ_MASK_OFS);
  assign hit_flag = (paddr == `CFM_IRQ_FLAG_OFS);
  assign hit_status = (paddr == `CFM_STATUS_OFS);
  assign mapped = hit_ctrl | hit_ev | hit_mask | hit_flag | hit_status;

  // Monitor gating
  wire awake;
  wire mon_active;
  wire int_rise;
  wire ext_rise;
  wire ext_fall;
  wire presc_wrap;
  wire safe_tick;
  wire win_end;
  wire [`CFM_STARTUP_W-1:0] startup_len;
  wire startup_done;
  wire fail_now;
  wire new_fail;
  wire ready_evt;
  wire restore_req;
  wire [7:0] presc_len;

  assign awake = ~sleep_mode | ext_osc_request;
  assign mon_active = osc_en_bit & fail_monitor_enable & awake & osc_ready;

  // Edge strobes of the sampled oscillator pins
  cfm_edge_detect #(
    .IDLE_LEVEL(`CFM_EDGE_IDLE)
  ) ext_edge_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin(ext_osc_clk),
    .pin_q(ext_q),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  cfm_edge_detect #(
    .IDLE_LEVEL(`CFM_EDGE_IDLE)
  ) int_edge_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin(internal_fast_osc_clk),
    .pin_q(),
    .rise(int_rise),
    .fall()
  );

  // Prescaler length: half period of safe clock in oscillator edges
  assign presc_len = 8'h01 << presc_sel;
  assign presc_wrap = int_rise & (presc_cnt >= presc_len - 8'h01);
  assign safe_tick = presc_wrap & ~safe_clk;
  assign win_end = safe_tick & (win_cnt == `CFM_WINDOW_TICKS);

  assign startup_len = {{(`CFM_STARTUP_W-1){1'b0}}, 1'b1} << startup_sel;
  assign startup_done = (startup_cnt >= startup_len);

  // Edge seen in the final cycle of a window counts too
  assign fail_now = ~((rise_seen | ext_rise) & (fall_seen | ext_fall));
  assign new_fail = mon_active & win_end & fail_now & ~clock_fail_flag;
  assign ready_evt = osc_en_bit & startup_done & ~osc_ready;
  assign restore_req = wr_acc & hit_ctrl & pwdata[`CFM_CTRL_RESTORE];

  assign irq = |(irq_flag & irq_mask);

  // Read data and error, latched in the setup phase
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en && setup_ph) begin
      pslverr <= ~mapped;
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        if (hit_ctrl) begin
          prdata[`CFM_CTRL_OSC_EN] <= osc_en_bit;
          prdata[`CFM_CTRL_MON_EN] <= fail_monitor_enable;
          prdata[`CFM_CTRL_STARTUP_MSB:`CFM_CTRL_STARTUP_LSB] <= startup_sel;
          prdata[`CFM_CTRL_PRESC_MSB:`CFM_CTRL_PRESC_LSB] <= presc_sel;
        end
        if (hit_ev) begin
          prdata[`CFM_EV_OUT_EN] <= fail_event_output_enable;
        end
        if (hit_mask) begin
          prdata[`CFM_IRQ_W-1:0] <= irq_mask;
        end
        if (hit_flag) begin
          prdata[`CFM_IRQ_W-1:0] <= irq_flag;
        end
        if (hit_status) begin
          prdata[`CFM_ST_FAIL] <= clock_fail_flag;
          prdata[`CFM_ST_SWITCHED] <= clock_switched_flag;
          prdata[`CFM_ST_READY] <= osc_ready;
          prdata[`CFM_ST_ACTIVE] <= mon_active;
        end
      end
    end
  end

  // Configuration registers, cleared by power-on reset only
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      osc_en_bit <= `CFM_CTRL_OSC_EN_RST;
      fail_monitor_enable <= `CFM_CTRL_MON_EN_RST;
      startup_sel <= `CFM_CTRL_STARTUP_RST;
      presc_sel <= `CFM_CTRL_PRESC_RST;
      fail_event_output_enable <= `CFM_EVENT_CONTROL_RST;
      irq_mask <= `CFM_IRQ_RST;
    end else if (wr_acc) begin
      if (hit_ctrl) begin
        osc_en_bit <= pwdata[`CFM_CTRL_OSC_EN];
        fail_monitor_enable <= pwdata[`CFM_CTRL_MON_EN];
        startup_sel <= pwdata[`CFM_CTRL_STARTUP_MSB:`CFM_CTRL_STARTUP_LSB];
        presc_sel <= pwdata[`CFM_CTRL_PRESC_MSB:`CFM_CTRL_PRESC_LSB];
      end
      if (hit_ev) begin
        fail_event_output_enable <= pwdata[`CFM_EV_OUT_EN];
      end
      if (hit_mask) begin
        irq_mask <= pwdata[`CFM_IRQ_W-1:0];
      end
    end
  end

  // Oscillator enable follows software and sleep gating, never the monitor
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_osc_enable <= 1'b0;
    end else if (clk_en) begin
      ext_osc_enable <= osc_en_bit & awake;
    end
  end

  // Interrupt flags: set wins over read clear and write-one clear
  reg [`CFM_IRQ_W-1:0] next_irq_flag;
  always @* begin
    next_irq_flag = irq_flag;
    if (rd_acc && hit_flag) begin
      next_irq_flag = next_irq_flag & ~prdata[`CFM_IRQ_W-1:0];
    end
    if (wr_acc && hit_flag) begin
      next_irq_flag = next_irq_flag & ~pwdata[`CFM_IRQ_W-1:0];
    end
    if (new_fail) begin
      next_irq_flag[`CFM_IRQ_FAIL] = 1'b1;
    end
    if (ready_evt) begin
      next_irq_flag[`CFM_IRQ_READY] = 1'b1;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_flag <= `CFM_IRQ_RST;
    end else if (clk_en) begin
      irq_flag <= next_irq_flag;
    end
  end

  // Safe clock prescaler
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      presc_cnt <= 8'h00;
      safe_clk <= 1'b0;
    end else if (clk_en) begin
      if (presc_wrap) begin
        presc_cnt <= 8'h00;
        safe_clk <= ~safe_clk;
      end else if (int_rise) begin
        presc_cnt <= presc_cnt + 8'h01;
      end
    end
  end

  // Start-up wait after each oscillator start or restart
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      startup_cnt <= {`CFM_STARTUP_W{1'b0}};
      osc_ready <= 1'b0;
    end else if (clk_en) begin
      if (!osc_en_bit || !awake) begin
        startup_cnt <= {`CFM_STARTUP_W{1'b0}};
        osc_ready <= 1'b0;
      end else if (!startup_done) begin
        startup_cnt <= startup_cnt + {{(`CFM_STARTUP_W-1){1'b0}}, 1'b1};
      end else begin
        osc_ready <= 1'b1;
      end
    end
  end

  // Monitor window over four safe clock periods
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      win_cnt <= 2'h0;
      rise_seen <= 1'b0;
      fall_seen <= 1'b0;
      clock_fail_flag <= 1'b0;
    end else if (clk_en) begin
      if (!mon_active) begin
        win_cnt <= 2'h0;
        rise_seen <= 1'b0;
        fall_seen <= 1'b0;
        clock_fail_flag <= 1'b0;
      end else if (win_end) begin
        win_cnt <= 2'h0;
        rise_seen <= 1'b0;
        fall_seen <= 1'b0;
        clock_fail_flag <= fail_now;
      end else begin
        if (safe_tick) begin
          win_cnt <= win_cnt + 2'h1;
        end
        if (ext_rise) begin
          rise_seen <= 1'b1;
        end
        if (ext_fall) begin
          fall_seen <= 1'b1;
        end
      end
    end
  end

  // Clock switch: set by failure, cleared by software after recovery
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clock_switched_flag <= 1'b0;
    end else if (clk_en) begin
      if (new_fail) begin
        clock_switched_flag <= 1'b1;
      end else if (restore_req && !clock_fail_flag) begin
        clock_switched_flag <= 1'b0;
      end
    end
  end

  // Failure event and downstream clock
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fail_event <= 1'b0;
      clk_out <= 1'b0;
      clk_select_safe <= 1'b0;
    end else if (clk_en) begin
      fail_event <= new_fail & fail_event_output_enable;
      clk_select_safe <= clock_switched_flag;
      clk_out <= clock_switched_flag ? safe_clk : ext_q;
    end else begin
      fail_event <= 1'b0;
    end
  end

endmodule

// Registered copy of a sampled pin with its edge strobes
module cfm_edge_detect #(
  parameter IDLE_LEVEL = `CFM_EDGE_IDLE
) (
  // Clock, reset, clock enable
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  // Pin and its edge strobes
  input wire pin,
  output reg pin_q,
  output wire rise,
  output wire fall
);

  assign rise = pin & ~pin_q;
  assign fall = ~pin & pin_q;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= IDLE_LEVEL;
    end else if (clk_en) begin
      pin_q <= pin;
    end
  end

endmodule
`default_nettype wire

// ===== dv/cfm_props.sv
// Port checker of the clock fail monitor
`timescale 1ns/1ns
`default_nettype none
`include "cfm_regs.vh"
module cfm_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Clocks and event
  input wire logic ext_osc_clk,
  input wire logic ext_osc_enable,
  input wire logic safe_clk,
  input wire logic clk_out,
  input wire logic clk_select_safe,
  input wire logic fail_event
);
  logic mapped;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_ready_no_wait: assert property (pready == (psel && penable))
    else $error("pready not psel and penable");
  a_slverr_unmapped: assert property (psel && penable && $past(clk_en) |-> pslverr == !mapped)
    else $error("pslverr does not match address");
  a_restore_by_write: assert property ($fell(clk_select_safe) |->
    $past(psel && penable && pwrite && paddr == `CFM_CTRL_OFS && pwdata[2], 2))
    else $error("switch back without restore write");
  a_switch_keeps_osc: assert property ($rose(clk_select_safe) |-> ext_osc_enable)
    else $error("oscillator off at switch");
  a_event_with_switch: assert property (fail_event |=> clk_select_safe)
    else $error("event without safe clock");
  a_event_one_cycle: assert property (fail_event |=> !fail_event [*3])
    else $error("event longer than one cycle");
  a_off_no_event: assert property (!ext_osc_enable [*4] |-> !fail_event)
    else $error("event while oscillator off");
  a_clock_mux_path: assert property (clk_en && $past(clk_en) |=>
    clk_out == (clk_select_safe ? $past(safe_clk) : $past(ext_osc_clk, 2)))
    else $error("clk_out from wrong source");
endmodule
bind cfm_clock_fail_monitor cfm_props cfm_props_inst (.mclk(mclk), .reset_n(reset_n),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .ext_osc_clk(ext_osc_clk),
  .ext_osc_enable(ext_osc_enable), .safe_clk(safe_clk), .clk_out(clk_out),
  .clk_select_safe(clk_select_safe), .fail_event(fail_event));
`default_nettype wire

// ===== dv/cfm_osc_model.sv
// External and internal oscillator model
`timescale 1ns/1ns
`default_nettype none
module cfm_osc_model (
  // Fault control
  input wire logic run,
  // Oscillator outputs
  output logic ext_clk,
  output logic int_clk
);
  // External clock stalls at its level while run is low, toggles clear of mclk edges
  initial begin
    ext_clk = 1'b0;
    int_clk = 1'b0;
    #5;
    forever #50 if (run) ext_clk = ~ext_clk;
  end
  // Runs from power-up, ahead of monitoring
  always #60 int_clk = ~int_clk;
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Testbench of the clock fail monitor
`timescale 1ns/1ns
`default_nettype none
`include "cfm_regs.vh"
module tb;
  logic mclk, reset_n, clk_en, psel, penable, pwrite, run, serr;
  logic sleep_mode, ext_osc_request;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  wire logic pready, pslverr, ext_osc_clk, int_clk, ext_osc_enable, irq;
  wire logic safe_clk, clk_out, clk_select_safe, fail_event;
  wire logic [31:0] prdata;
  int miscompares = 0;
  int checked = 0;
  int ev_cnt = 0;
  time t0, t1;
  cfm_clock_fail_monitor cfm_clock_fail_monitor_inst (.mclk(mclk), .reset_n(reset_n),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_osc_clk(ext_osc_clk), .internal_fast_osc_clk(int_clk), .sleep_mode(sleep_mode),
    .ext_osc_request(ext_osc_request), .ext_osc_enable(ext_osc_enable),
    .safe_clk(safe_clk), .clk_out(clk_out), .clk_select_safe(clk_select_safe),
    .fail_event(fail_event), .irq(irq));
  cfm_osc_model cfm_osc_model_inst (.run(run), .ext_clk(ext_osc_clk), .int_clk(int_clk));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) if (fail_event === 1'b1) ev_cnt <= ev_cnt + 1;
  task print_verdict;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] a, input logic [31:0] e);
    checked++;
    if (a !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  initial begin
    #400000;
    miscompares++;
    print_verdict;
  end
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b0;
    sleep_mode = 1'b0;
    ext_osc_request = 1'b0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int a = 0; a <= 16; a += 4) rd(a[7:0], 32'h0);
    rd(8'h14, 32'h0);
    chk({31'h0, serr}, 32'h1);
    wr(`CFM_CTRL_OFS, 32'h2);
    repeat (300) @(posedge mclk);
    rd(`CFM_STATUS_OFS, 32'h0);
    wr(`CFM_IRQ_MASK_OFS, 32'h1);
    wr(`CFM_EVENT_CONTROL_OFS, 32'h1);
    run <= 1'b1;
    wr(`CFM_CTRL_OFS, 32'h3);
    repeat (300) @(posedge mclk);
    rd(`CFM_STATUS_OFS, 32'hc);
    chk({31'h0, irq}, 32'h0);
    run <= 1'b0;
    repeat (300) @(posedge mclk);
    chk(ev_cnt, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(`CFM_STATUS_OFS, 32'hf);
    chk({31'h0, ext_osc_enable}, 32'h1);
    wr(`CFM_CTRL_OFS, 32'h7);
    repeat (3) @(posedge mclk);
    chk({31'h0, clk_select_safe}, 32'h1);
    wr(`CFM_IRQ_FLAG_OFS, 32'h2);
    wr(`CFM_IRQ_FLAG_OFS, 32'h0);
    rd(`CFM_IRQ_FLAG_OFS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    run <= 1'b1;
    repeat (300) @(posedge mclk);
    rd(`CFM_STATUS_OFS, 32'he);
    wr(`CFM_CTRL_OFS, 32'h7);
    repeat (3) @(posedge mclk);
    chk({31'h0, clk_select_safe}, 32'h0);
    wr(`CFM_CTRL_OFS, 32'h243);
    rd(`CFM_CTRL_OFS, 32'h243);
    @(posedge safe_clk) t0 = $time;
    @(negedge safe_clk) t1 = $time;
    chk(32'((t1 - t0) / 20), 32'd24);
    wr(`CFM_EVENT_CONTROL_OFS, 32'h0);
    wr(`CFM_IRQ_MASK_OFS, 32'h0);
    sleep_mode <= 1'b1;
    run <= 1'b0;
    repeat (300) @(posedge mclk);
    chk({31'h0, ext_osc_enable}, 32'h0);
    chk(ev_cnt, 32'h1);
    ext_osc_request <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`CFM_STATUS_OFS, 32'h0);
    repeat (600) @(posedge mclk);
    chk({31'h0, ext_osc_enable}, 32'h1);
    rd(`CFM_STATUS_OFS, 32'hf);
    chk(ev_cnt, 32'h1);
    chk({31'h0, irq}, 32'h0);
    clk_en <= 1'b0;
    wr(`CFM_IRQ_MASK_OFS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    clk_en <= 1'b1;
    rd(`CFM_IRQ_MASK_OFS, 32'h0);
    print_verdict;
  end
endmodule
`default_nettype wire
